// File: verilog/sct_pkg.sv
// Shared constants for the switched-capacitance touch sequencer.
// Assumes a single 250 MHz core clock; no other clock reaches the block.
package sct_pkg;

	// Register indices; byte address on the bus is index times four
	localparam logic [15:0] IDX_CONFIG = 16'ha150;
	localparam logic [15:0] IDX_ANALOG = 16'ha151;
	localparam logic [15:0] IDX_COMMAND = 16'ha152;
	localparam logic [15:0] IDX_COUNT_LO = 16'ha153;
	localparam logic [15:0] IDX_COUNT_HI = 16'ha154;
	localparam logic [15:0] IDX_EVT_STATUS = 16'ha158;
	localparam logic [15:0] IDX_EVT_MASK = 16'ha159;
	localparam int ADDR_W = 18;
	localparam int DATA_W = 32;

	// Config register fields
	localparam int CFG_ENABLE = 7;
	localparam int CFG_PSR = 6;
	localparam int CFG_REFLVL = 5;
	localparam int CFG_VTH = 4;
	localparam int CFG_CDT_HI = 3;
	// Analog config fields
	localparam int ACFG_PD = 7;
	localparam int ACFG_ZERO_HI = 6;
	localparam int ACFG_ZERO_LO = 4;
	localparam int ACFG_FIL_HI = 3;
	// Command register fields
	localparam int CMD_INTEN = 7;
	localparam int CMD_CNT_HI = 6;
	localparam int CMD_CNT_LO = 5;
	localparam int CMD_AUTO_RIGHT_SHIFT = 4;
	localparam int CMD_RPT_HI = 3;
	localparam int CMD_RPT_LO = 2;
	localparam int CMD_SENSE_IRQ_FLAG = 1;
	localparam int CMD_START = 0;
	// Event status / mask bits
	localparam int EVT_DONE = 0;
	localparam int EVT_REFUSED = 1;
	localparam int EVT_W = 2;

	localparam logic [7:0] REG_RESET = 8'h00;

	// Discharge timing in core clock periods
	localparam int ZERO_PRE = 4;
	localparam int ZERO_STEP = 128;
	localparam int ZERO_POST = 1;
	localparam int ZERO_W = 11;

	localparam int CNT_W = 18;
	localparam int ACC_W = 21;
	localparam int FIL_DEPTH = 15;
	localparam logic [7:0] LFSR_SEED = 8'h01;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ZERO,
		ST_CHARGE,
		ST_DUMP
	} sct_state_e;

	typedef struct packed {
		sct_state_e st;
		logic [7:0] cfg;
		logic [7:0] acfg;
		logic inten;
		logic auto_right_shift;
		logic [1:0] repeat_count;
		logic flag;
		logic busy;
		logic [CNT_W-1:0] count;
		logic [CNT_W-1:0] conv;
		logic [ACC_W-1:0] acc;
		logic [2:0] rep_left;
		logic [ZERO_W-1:0] tmr;
		logic [EVT_W-1:0] status;
		logic [EVT_W-1:0] mask;
		logic ack;
		logic [7:0] rdata;
		logic [7:0] lfsr;
	} sct_top_s;

endpackage : sct_pkg

// File: verilog/sct_cmp_if.sv
// Carrier between the sequencer and its comparator filter.
// Assumes both ends sit on the same core clock.
`timescale 1ns/1ns
`default_nettype none
interface sct_cmp_if;
	logic comp_raw;
	logic [3:0] filt_len;
	logic filt_out;
	modport filt (input comp_raw, input filt_len, output filt_out);
	modport seq (output comp_raw, output filt_len, input filt_out);
endinterface : sct_cmp_if
`default_nettype wire

// File: verilog/sct_cmp_filter.sv
// Comparator synchroniser and run-length filter.
// Assumes the comparator pin is asynchronous to the core clock.
`timescale 1ns/1ns
`default_nettype none
module sct_cmp_filter (
	input wire logic clk_i,
	input wire logic nrst_i,
	sct_cmp_if.filt cmp
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic stable;
		logic [sct_pkg::FIL_DEPTH-1:0] hist;
		logic out;
	} sct_fil_s;

	sct_fil_s s_q;
	sct_fil_s s_d;

	// Next state: sync chain, agreement gate, history window
	always_comb begin
		logic all_one;
		logic [3:0] n;
		all_one = 1'b1;
		n = (cmp.filt_len == 4'h0) ? 4'h1 : cmp.filt_len; // Zero treated as one sample
		s_d = s_q;
		s_d.s1 = cmp.comp_raw;
		s_d.s2 = s_q.s1;
		s_d.s3 = s_q.s2;
		// Only a level seen by both late stages counts
		if (s_q.s2 == s_q.s3) begin
			s_d.stable = s_q.s3;
		end
		s_d.hist = {s_q.hist[sct_pkg::FIL_DEPTH-2:0], s_q.stable};
		for (int i = 0; i < sct_pkg::FIL_DEPTH; i++) begin
			if ((i < int'(n)) && !s_d.hist[i]) begin
				all_one = 1'b0;
			end
		end
		s_d.out = all_one;
	end

	// State register
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign cmp.filt_out = s_q.out;
endmodule : sct_cmp_filter
`default_nettype wire

// File: verilog/sct_touch_seq.sv
// Switched-capacitance touch-key sequencer with Avalon-MM register slave.
// Assumes SYS_CLK_I is the internal oscillator and the analog switches,
// comparator and pad live outside; COMP_I is asynchronous.
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Runs only while sense_enable set
// - Core clock is the oscillator clock
// - Discharge reference first, then release switch
// - Discharge lasts 4+128*(len+1)+1 cycles
// - Optional pad pulldown for (len+1)*128 cycles
// - Charge key, dump to reference, count
// - Each interval lasts charge_dump_time+1 cycles
// - Threshold select: half or three quarters
// - Reference level select, default 1.8V
// - Filter trips after N high samples
// - Trip ends detection, stores count, flags
// - Count cleared on start, holds result
// - 18-bit count, top bits in command
// - Auto shift divides summed repeat counts
// - Hardware sets flag, only software clears
// - Interrupt when flag and enable set
module sct_touch_seq (
	input wire logic SYS_CLK_I,
	input wire logic NRST_I,
	input wire logic [sct_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [sct_pkg::DATA_W-1:0] AVS_WRITEDATA_I,
	input wire logic [3:0] AVS_BYTEENABLE_I,
	output logic [sct_pkg::DATA_W-1:0] AVS_READDATA_O,
	output logic AVS_WAITREQUEST_O,
	input wire logic COMP_I,
	output logic REF_DISCHARGE_O,
	output logic PAD_PULLDOWN_O,
	output logic KEY_CHARGE_O,
	output logic KEY_DUMP_O,
	output logic THRESH_SEL_O,
	output logic REF_LEVEL_SEL_O,
	output logic CURRENT_DITHER_O,
	output logic BUSY_O,
	output logic IRQ_O
);
	localparam sct_pkg::sct_top_s RST = '{
		st: sct_pkg::ST_IDLE,
		lfsr: sct_pkg::LFSR_SEED,
		default: '0
	};

	sct_pkg::sct_top_s s_q;
	sct_pkg::sct_top_s s_d;

	sct_cmp_if cmp ();

	// Address match against a register index
	function automatic logic reg_hit(input logic [sct_pkg::ADDR_W-1:0] a, input logic [15:0] idx);
		reg_hit = (a == {idx, 2'b00});
	endfunction : reg_hit

	// Total discharge length for a zero-length field
	function automatic logic [sct_pkg::ZERO_W-1:0] zero_total(input logic [2:0] z);
		zero_total = sct_pkg::ZERO_W'(sct_pkg::ZERO_PRE + sct_pkg::ZERO_STEP * (int'(z) + 1)
			+ sct_pkg::ZERO_POST);
	endfunction : zero_total

	// Pad pulldown length for a zero-length field
	function automatic logic [sct_pkg::ZERO_W-1:0] pd_len(input logic [2:0] z);
		pd_len = sct_pkg::ZERO_W'(sct_pkg::ZERO_STEP * (int'(z) + 1));
	endfunction : pd_len

	// Filter sits in its own module so the sync chain stays isolated
	sct_cmp_filter u_filter (
		.clk_i(SYS_CLK_I),
		.nrst_i(NRST_I),
		.cmp(cmp.filt)
	);

	assign cmp.comp_raw = COMP_I;
	assign cmp.filt_len = s_q.acfg[sct_pkg::ACFG_FIL_HI:0];

	// Next-state logic: bus side first, so hardware sets below win
	always_comb begin
		logic req;
		logic acc_now;
		logic wr;
		logic be0;
		logic [7:0] wd;
		logic [7:0] rd;
		logic start_req;
		logic [2:0] zlen;
		logic [3:0] cdt;
		logic [sct_pkg::ACC_W-1:0] sum;
		logic [sct_pkg::CNT_W-1:0] conv_inc;
		req = AVS_READ_I | AVS_WRITE_I;
		acc_now = req & s_q.ack;
		wr = acc_now & AVS_WRITE_I;
		be0 = AVS_BYTEENABLE_I[0];
		wd = AVS_WRITEDATA_I[7:0];
		rd = 8'h00;
		start_req = 1'b0;
		zlen = s_q.acfg[sct_pkg::ACFG_ZERO_HI:sct_pkg::ACFG_ZERO_LO];
		cdt = s_q.cfg[sct_pkg::CFG_CDT_HI:0];
		sum = '0;
		conv_inc = s_q.conv + sct_pkg::CNT_W'(1);
		s_d = s_q;

		// One wait state: ack rises after the first request cycle
		s_d.ack = req & ~s_q.ack;

		// Read data captured in the wait cycle, shown when waitrequest drops
		if (reg_hit(AVS_ADDRESS_I, sct_pkg::IDX_CONFIG)) begin
			rd = s_q.cfg;
		end else if (reg_hit(AVS_ADDRESS_I, sct_pkg::IDX_ANALOG)) begin
			rd = s_q.acfg;
		end else if (reg_hit(AVS_ADDRESS_I, sct_pkg::IDX_COMMAND)) begin
			rd = {s_q.inten, s_q.count[sct_pkg::CNT_W-1:sct_pkg::CNT_W-2], s_q.auto_right_shift,
				s_q.repeat_count, s_q.flag, s_q.busy};
		end else if (reg_hit(AVS_ADDRESS_I, sct_pkg::IDX_COUNT_LO)) begin
			rd = s_q.count[7:0];
		end else if (reg_hit(AVS_ADDRESS_I, sct_pkg::IDX_COUNT_HI)) begin
			rd = s_q.count[15:8];
		end else if (reg_hit(AVS_ADDRESS_I, sct_pkg::IDX_EVT_STATUS)) begin
			rd = {{(8 - sct_pkg::EVT_W){1'b0}}, s_q.status};
		end else if (reg_hit(AVS_ADDRESS_I, sct_pkg::IDX_EVT_MASK)) begin
			rd = {{(8 - sct_pkg::EVT_W){1'b0}}, s_q.mask};
		end else begin
			rd = 8'h00; // Unmapped reads as zero
		end
		if (AVS_READ_I && !s_q.ack) begin
			s_d.rdata = rd;
		end

		// Read of event status clears it; an event this cycle still lands
		if (acc_now && AVS_READ_I && reg_hit(AVS_ADDRESS_I, sct_pkg::IDX_EVT_STATUS)) begin
			s_d.status = '0;
		end

		// Register writes; low byte lane carries the data
		if (wr && be0) begin
			if (reg_hit(AVS_ADDRESS_I, sct_pkg::IDX_CONFIG)) begin
				s_d.cfg = wd;
			end else if (reg_hit(AVS_ADDRESS_I, sct_pkg::IDX_ANALOG)) begin
				s_d.acfg = wd;
			end else if (reg_hit(AVS_ADDRESS_I, sct_pkg::IDX_COMMAND)) begin
				s_d.inten = wd[sct_pkg::CMD_INTEN];
				s_d.auto_right_shift = wd[sct_pkg::CMD_AUTO_RIGHT_SHIFT];
				s_d.repeat_count = wd[sct_pkg::CMD_RPT_HI:sct_pkg::CMD_RPT_LO];
				s_d.flag = wd[sct_pkg::CMD_SENSE_IRQ_FLAG];
				start_req = wd[sct_pkg::CMD_START];
			end else if (reg_hit(AVS_ADDRESS_I, sct_pkg::IDX_COUNT_LO)) begin
				s_d.count[7:0] = wd;
			end else if (reg_hit(AVS_ADDRESS_I, sct_pkg::IDX_COUNT_HI)) begin
				s_d.count[15:8] = wd;
			end else if (reg_hit(AVS_ADDRESS_I, sct_pkg::IDX_EVT_MASK)) begin
				s_d.mask = wd[sct_pkg::EVT_W-1:0];
			end
		end

		// Sequencer
		case (s_q.st)
			sct_pkg::ST_IDLE: begin
				if (start_req) begin
					if (!s_q.cfg[sct_pkg::CFG_ENABLE]) begin
						s_d.status[sct_pkg::EVT_REFUSED] = 1'b1;
					end else begin
						s_d.count = '0;
						s_d.conv = '0;
						s_d.acc = '0;
						s_d.busy = 1'b1;
						s_d.rep_left = 3'((1 << s_d.repeat_count) - 1);
						s_d.st = sct_pkg::ST_ZERO;
						s_d.tmr = zero_total(zlen) - sct_pkg::ZERO_W'(1);
					end
				end
			end
			sct_pkg::ST_ZERO: begin
				if (s_q.tmr == '0) begin
					s_d.st = sct_pkg::ST_CHARGE;
					s_d.tmr = sct_pkg::ZERO_W'(cdt);
				end else begin
					s_d.tmr = s_q.tmr - sct_pkg::ZERO_W'(1);
				end
			end
			sct_pkg::ST_CHARGE: begin
				if (s_q.tmr == '0) begin
					s_d.st = sct_pkg::ST_DUMP;
					s_d.tmr = sct_pkg::ZERO_W'(cdt);
				end else begin
					s_d.tmr = s_q.tmr - sct_pkg::ZERO_W'(1);
				end
			end
			sct_pkg::ST_DUMP: begin
				if (s_q.tmr != '0) begin
					s_d.tmr = s_q.tmr - sct_pkg::ZERO_W'(1);
				end else begin
					s_d.conv = conv_inc;
					s_d.lfsr = {s_q.lfsr[6:0], s_q.lfsr[7] ^ s_q.lfsr[5] ^ s_q.lfsr[4] ^ s_q.lfsr[3]};
					s_d.st = sct_pkg::ST_CHARGE;
					s_d.tmr = sct_pkg::ZERO_W'(cdt);
					if (cmp.filt_out) begin
						sum = s_q.acc + sct_pkg::ACC_W'(conv_inc);
						s_d.acc = sum;
						if (s_q.rep_left != '0) begin
							s_d.rep_left = s_q.rep_left - 3'd1;
							s_d.conv = '0;
							s_d.st = sct_pkg::ST_ZERO;
							s_d.tmr = zero_total(zlen) - sct_pkg::ZERO_W'(1);
						end else begin
							if (s_q.auto_right_shift) begin
								sum = sum >> s_q.repeat_count;
							end
							s_d.count = sum[sct_pkg::CNT_W-1:0];
							s_d.busy = 1'b0;
							s_d.st = sct_pkg::ST_IDLE;
							s_d.flag = 1'b1;
							s_d.status[sct_pkg::EVT_DONE] = 1'b1;
						end
					end
				end
			end
			default: begin
				s_d.st = sct_pkg::ST_IDLE;
			end
		endcase

		if (!s_q.cfg[sct_pkg::CFG_ENABLE] && s_q.st != sct_pkg::ST_IDLE) begin
			s_d.st = sct_pkg::ST_IDLE;
			s_d.busy = 1'b0;
		end
	end

	// Whole block on the oscillator clock
	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			s_q <= RST;
		end else begin
			s_q <= s_d;
		end
	end

	// Bus answers
	assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~s_q.ack;
	assign AVS_READDATA_O = {{(sct_pkg::DATA_W - 8){1'b0}}, s_q.rdata};

	assign REF_DISCHARGE_O = (s_q.st == sct_pkg::ST_ZERO);
	// Pulldown over the first part of discharge
	assign PAD_PULLDOWN_O = (s_q.st == sct_pkg::ST_ZERO) && s_q.acfg[sct_pkg::ACFG_PD]
		&& (s_q.tmr >= zero_total(s_q.acfg[sct_pkg::ACFG_ZERO_HI:sct_pkg::ACFG_ZERO_LO])
		- pd_len(s_q.acfg[sct_pkg::ACFG_ZERO_HI:sct_pkg::ACFG_ZERO_LO]));
	// Charge and dump phases never overlap
	assign KEY_CHARGE_O = (s_q.st == sct_pkg::ST_CHARGE);
	assign KEY_DUMP_O = (s_q.st == sct_pkg::ST_DUMP);
	assign THRESH_SEL_O = s_q.cfg[sct_pkg::CFG_VTH];
	assign REF_LEVEL_SEL_O = s_q.cfg[sct_pkg::CFG_REFLVL];
	// Dither bit only moves when enabled, to keep current steady otherwise
	assign CURRENT_DITHER_O = s_q.cfg[sct_pkg::CFG_PSR] & s_q.lfsr[0];
	assign BUSY_O = s_q.busy;
	// Flag and enable, plus masked events
	assign IRQ_O = (s_q.flag & s_q.inten) | (|(s_q.status & s_q.mask));
endmodule : sct_touch_seq
`default_nettype wire

// File: testbench/sct_cap_model.sv
// Behavioural reference and key capacitor pair with its comparator.
// Assumes the switch controls come straight from the core clock domain.
`timescale 1ns/1ns
`default_nettype none
module sct_cap_model (
	input wire logic clk_i,
	input wire logic discharge_i,
	input wire logic dump_i,
	input wire logic [7:0] trip_i,
	output logic comp_o
);
	logic [7:0] dumps;
	logic dump_d;
	initial begin
		dumps = 8'h00;
		dump_d = 1'b0;
	end
	// Grounding empties, each dump adds charge
	always @(posedge clk_i) begin
		dump_d <= dump_i;
		if (discharge_i) begin
			dumps <= 8'h00;
		end else if (dump_i && !dump_d) begin
			dumps <= dumps + 8'h01;
		end
	end
	assign comp_o = !discharge_i && (dumps >= trip_i);
endmodule : sct_cap_model
`default_nettype wire

// File: testbench/sct_touch_seq_chk.sv
// Port-level assertions for the touch sequencer.
// Assumes register writes reach the block only over its Avalon slave.
`timescale 1ns/1ns
`default_nettype none
module sct_touch_seq_chk (
	input wire logic SYS_CLK_I,
	input wire logic NRST_I,
	input wire logic [sct_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [sct_pkg::DATA_W-1:0] AVS_WRITEDATA_I,
	input wire logic [3:0] AVS_BYTEENABLE_I,
	input wire logic AVS_WAITREQUEST_O,
	input wire logic REF_DISCHARGE_O,
	input wire logic PAD_PULLDOWN_O,
	input wire logic KEY_CHARGE_O,
	input wire logic KEY_DUMP_O,
	input wire logic THRESH_SEL_O,
	input wire logic REF_LEVEL_SEL_O,
	input wire logic BUSY_O,
	input wire logic IRQ_O
);
	logic wr_ok;
	logic [7:0] cfg_q;
	logic [7:0] acfg_q;
	logic ie_q;
	logic [10:0] dis_q;
	logic [10:0] pd_q;
	logic [10:0] ch_q;
	logic [10:0] du_q;
	// Shadow of the config, analog config and interrupt enable fields
	assign wr_ok = AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_BYTEENABLE_I[0];
	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			cfg_q <= 8'h00;
			acfg_q <= 8'h00;
			ie_q <= 1'b0;
			dis_q <= 11'h000;
			pd_q <= 11'h000;
			ch_q <= 11'h000;
			du_q <= 11'h000;
		end else begin
			if (wr_ok && AVS_ADDRESS_I == {sct_pkg::IDX_CONFIG, 2'b00}) begin
				cfg_q <= AVS_WRITEDATA_I[7:0];
			end
			if (wr_ok && AVS_ADDRESS_I == {sct_pkg::IDX_ANALOG, 2'b00}) begin
				acfg_q <= AVS_WRITEDATA_I[7:0];
			end
			if (wr_ok && AVS_ADDRESS_I == {sct_pkg::IDX_COMMAND, 2'b00}) begin
				ie_q <= AVS_WRITEDATA_I[7];
			end
			// Run lengths; cleared whenever the phase is off
			dis_q <= REF_DISCHARGE_O ? dis_q + 11'h001 : 11'h000;
			pd_q <= PAD_PULLDOWN_O ? pd_q + 11'h001 : 11'h000;
			ch_q <= KEY_CHARGE_O ? ch_q + 11'h001 : 11'h000;
			du_q <= KEY_DUMP_O ? du_q + 11'h001 : 11'h000;
		end
	end
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!NRST_I);
	// Enable gating excludes aborts, where phases end early by design
	sequence s_disch_done;
		$fell(REF_DISCHARGE_O) ##0 cfg_q[7];
	endsequence
	sequence s_charge_run;
		KEY_CHARGE_O && !KEY_DUMP_O && !REF_DISCHARGE_O;
	endsequence
	a_disch_len: assert property (
		s_disch_done |-> dis_q == 5 + 128 * (acfg_q[6:4] + 1))
		else $error("discharge length wrong");
	a_phase_order: assert property (s_disch_done |-> s_charge_run)
		else $error("charge did not follow discharge");
	a_pull_len: assert property (
		$fell(PAD_PULLDOWN_O) && cfg_q[7] |-> pd_q == 128 * (acfg_q[6:4] + 1))
		else $error("pulldown length wrong");
	a_pull_gate: assert property (PAD_PULLDOWN_O |-> REF_DISCHARGE_O && acfg_q[7])
		else $error("pulldown outside discharge");
	a_charge_len: assert property (
		$fell(KEY_CHARGE_O) && cfg_q[7] |-> ch_q == cfg_q[3:0] + 1 ##0 KEY_DUMP_O)
		else $error("charge interval wrong");
	a_dump_len: assert property (
		$fell(KEY_DUMP_O) && cfg_q[7] |-> du_q == cfg_q[3:0] + 1)
		else $error("dump interval wrong");
	a_idle_quiet: assert property (
		!BUSY_O |-> !(REF_DISCHARGE_O || KEY_CHARGE_O || KEY_DUMP_O || PAD_PULLDOWN_O))
		else $error("switch active while idle");
	a_sel_follow: assert property (
		THRESH_SEL_O == cfg_q[4] && REF_LEVEL_SEL_O == cfg_q[5])
		else $error("threshold or level select wrong");
	a_done_irq: assert property ($fell(BUSY_O) && cfg_q[7] && ie_q |-> IRQ_O)
		else $error("no interrupt at completion");
	a_irq_hold: assert property ($fell(IRQ_O) |-> $past(AVS_READ_I || AVS_WRITE_I))
		else $error("interrupt dropped without access");
endmodule : sct_touch_seq_chk
bind sct_touch_seq sct_touch_seq_chk chk (.SYS_CLK_I(SYS_CLK_I), .NRST_I(NRST_I),
	.AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
	.AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
	.AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .REF_DISCHARGE_O(REF_DISCHARGE_O),
	.PAD_PULLDOWN_O(PAD_PULLDOWN_O), .KEY_CHARGE_O(KEY_CHARGE_O), .KEY_DUMP_O(KEY_DUMP_O),
	.THRESH_SEL_O(THRESH_SEL_O), .REF_LEVEL_SEL_O(REF_LEVEL_SEL_O), .BUSY_O(BUSY_O),
	.IRQ_O(IRQ_O));
`default_nettype wire

// File: testbench/sct_touch_seq_tb.sv
// Self-checking bench: a table of conversions, then refusal, register and reset cases.
// Assumes the capacitor model stands in for the analog side.
`timescale 1ns/1ns
`default_nettype none
module sct_touch_seq_tb;
	typedef struct packed {
		logic [7:0] cfg;
		logic [7:0] acfg;
		logic [1:0] repeat_count;
		logic ash;
		logic [7:0] trip;
		logic [17:0] cnt;
	} sct_row_s;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [17:0] addr = 18'h00000;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h00000000;
	logic [31:0] rdata;
	logic wait_r, comp, disch, pd, dump, busy, irq;
	logic [7:0] trip = 8'h01;
	logic [7:0] d;
	int bad_count = 0;
	int n_compared = 0;
	// Long charge/dump keeps the filter delay inside one dump interval
	sct_row_s rows [5] = '{
		'{8'h8f, 8'h01, 2'h0, 1'b0, 8'h05, 18'h00005},
		'{8'h9f, 8'h91, 2'h1, 1'b0, 8'h05, 18'h0000a},
		'{8'haf, 8'h01, 2'h2, 1'b1, 8'h06, 18'h00006},
		'{8'h8f, 8'h01, 2'h3, 1'b1, 8'h03, 18'h00003},
		'{8'h8f, 8'hf1, 2'h3, 1'b0, 8'h03, 18'h00018}};
	always #2 clk = ~clk;
	sct_touch_seq uut (.SYS_CLK_I(clk), .NRST_I(nrst), .AVS_ADDRESS_I(addr),
		.AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata),
		.AVS_BYTEENABLE_I(4'h1), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wait_r),
		.COMP_I(comp), .REF_DISCHARGE_O(disch), .PAD_PULLDOWN_O(pd), .KEY_CHARGE_O(),
		.KEY_DUMP_O(dump), .THRESH_SEL_O(), .REF_LEVEL_SEL_O(), .CURRENT_DITHER_O(),
		.BUSY_O(busy), .IRQ_O(irq));
	sct_cap_model cap (.clk_i(clk), .discharge_i(disch), .dump_i(dump), .trip_i(trip),
		.comp_o(comp));
	task automatic finish_test();
		$display("Compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// One bus access; waitrequest and read data are taken at the deciding rising edge
	task automatic acc(input logic we, input logic [15:0] idx, input logic [7:0] wd,
		output logic [7:0] q);
		int n;
		@(posedge clk);
		addr <= {idx, 2'b00};
		wr <= we;
		rd <= !we;
		wdata <= {24'h000000, wd};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wait_r !== 1'b0 && n < 50);
		q = rdata[7:0];
		wr <= 1'b0;
		rd <= 1'b0;
		if (n >= 50) begin
			bad_count++;
			finish_test();
		end
		// Let the edge's updates settle before callers look at outputs
		@(negedge clk);
	endtask : acc
	task automatic run(input sct_row_s r);
		logic [17:0] got;
		int n;
		trip <= r.trip;
		acc(1'b1, sct_pkg::IDX_CONFIG, r.cfg, d);
		acc(1'b1, sct_pkg::IDX_ANALOG, r.acfg, d);
		acc(1'b1, sct_pkg::IDX_COMMAND, {1'b1, 2'b00, r.ash, r.repeat_count, 2'b01}, d);
		acc(1'b0, sct_pkg::IDX_COUNT_LO, 8'h00, d);
		chk("count at start", {24'h000000, d}, 32'h0);
		n = 0;
		while (busy !== 1'b0 && n < 20000) begin
			@(negedge clk);
			n++;
		end
		if (n >= 20000) begin
			bad_count++;
			finish_test();
		end
		acc(1'b0, sct_pkg::IDX_COUNT_LO, 8'h00, got[7:0]);
		acc(1'b0, sct_pkg::IDX_COUNT_HI, 8'h00, got[15:8]);
		acc(1'b0, sct_pkg::IDX_COMMAND, 8'h00, d);
		got[17:16] = d[6:5];
		chk("count", {14'h0000, got}, {14'h0000, r.cnt});
		chk("busy bit", {31'h0, d[0]}, 32'h0);
		chk("flag", {31'h0, d[1]}, 32'h1);
		chk("irq", {31'h0, irq}, 32'h1);
		acc(1'b1, sct_pkg::IDX_COMMAND, 8'h80, d);
		chk("irq after clear", {31'h0, irq}, 32'h0);
	endtask : run
	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		foreach (rows[i]) begin
			run(rows[i]);
		end
		// Start while disabled: refused; status also holds the earlier done event, only refusal is unmasked
		acc(1'b1, sct_pkg::IDX_CONFIG, 8'h0f, d);
		acc(1'b1, sct_pkg::IDX_EVT_MASK, 8'h02, d);
		acc(1'b1, sct_pkg::IDX_COMMAND, 8'h01, d);
		repeat (4) @(negedge clk);
		chk("refused busy", {31'h0, busy}, 32'h0);
		chk("refused irq", {31'h0, irq}, 32'h1);
		acc(1'b0, sct_pkg::IDX_EVT_STATUS, 8'h00, d);
		chk("status", {24'h0, d}, 32'h3);
		acc(1'b0, sct_pkg::IDX_EVT_STATUS, 8'h00, d);
		chk("status cleared", {24'h0, d}, 32'h0);
		chk("irq cleared", {31'h0, irq}, 32'h0);
		// Count high byte is writable; unmapped reads give zero
		acc(1'b1, sct_pkg::IDX_COUNT_HI, 8'ha5, d);
		acc(1'b0, sct_pkg::IDX_COUNT_HI, 8'h00, d);
		chk("count high", {24'h0, d}, 32'ha5);
		acc(1'b0, 16'ha15f, 8'h00, d);
		chk("unmapped", {24'h0, d}, 32'h0);
		// Reset in mid-conversion returns the config, analog, command and count registers to zero
		acc(1'b1, sct_pkg::IDX_CONFIG, 8'h8f, d);
		acc(1'b1, sct_pkg::IDX_COMMAND, 8'h01, d);
		repeat (20) @(posedge clk);
		nrst <= 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		@(negedge clk);
		chk("busy after reset", {31'h0, busy}, 32'h0);
		for (int i = 0; i < 5; i++) begin
			acc(1'b0, sct_pkg::IDX_CONFIG + 16'(i), 8'h00, d);
			chk("reset value", {24'h0, d}, 32'h0);
		end
		finish_test();
	end
endmodule : sct_touch_seq_tb
`default_nettype wire
